// >>> hw/tmr16_pkg.sv
// constants for the 16-bit interval / square-wave / event timer
package tmr16_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [4:0] TMR16_ADR_MODE = 5'h00;
    localparam logic [4:0] TMR16_ADR_CCC = 5'h04;
    localparam logic [4:0] TMR16_ADR_OUTC = 5'h08;
    localparam logic [4:0] TMR16_ADR_PRE = 5'h0c;
    localparam logic [4:0] TMR16_ADR_CNT = 5'h10;
    localparam logic [4:0] TMR16_ADR_PRI = 5'h14;
    localparam logic [4:0] TMR16_ADR_SEC = 5'h18;
    localparam logic [4:0] TMR16_ADR_STAT = 5'h1c;
    // reset values
    localparam logic [7:0] TMR16_RST_8 = 8'h00;
    localparam logic [15:0] TMR16_RST_16 = 16'h0000;
    // mode control fields
    localparam int TMR16_MODE_HI = 3;
    localparam int TMR16_MODE_LO = 2;
    localparam logic [7:0] TMR16_MODE_MASK = 8'h0e;
    // output control fields
    localparam int TMR16_OC_OE = 0;
    localparam int TMR16_OC_INV_PRI = 1;
    localparam int TMR16_OC_SET_LO = 2;
    localparam int TMR16_OC_SET_HI = 3;
    localparam int TMR16_OC_INV_SEC = 4;
    localparam int TMR16_OC_OS_EN = 5;
    // trigger bits read back as zero
    localparam logic [7:0] TMR16_OC_RD_MASK = 8'h33;
    // prescaler mode fields
    localparam int TMR16_PRE_CLK_LO = 0;
    localparam int TMR16_PRE_EV_LO = 4;
    localparam logic [7:0] TMR16_PRE_MASK = 8'hf3;
    localparam logic [7:0] TMR16_CCC_MASK = 8'h07;
    // mode select codes
    typedef enum logic [1:0] {
        TMR16_MODE_STOP = 2'h0,
        TMR16_MODE_FREE = 2'h1,
        TMR16_MODE_EDGE_CLR = 2'h2,
        TMR16_MODE_MATCH_CLR = 2'h3
    } tmr16_mode_t;
    // count clock select codes
    localparam logic [1:0] TMR16_CLK_DIV1 = 2'h0;
    localparam logic [1:0] TMR16_CLK_DIV4 = 2'h1;
    localparam logic [1:0] TMR16_CLK_DIV256 = 2'h2;
    localparam logic [1:0] TMR16_CLK_EVENT = 2'h3;
    // prescale terminal counts (divisor minus one)
    localparam logic [7:0] TMR16_DIV4_END = 8'h03;
    localparam logic [7:0] TMR16_DIV256_END = 8'hff;
    // valid edge select codes
    localparam logic [1:0] TMR16_EDGE_FALL = 2'h0;
    localparam logic [1:0] TMR16_EDGE_RISE = 2'h1;
    localparam logic [1:0] TMR16_EDGE_BOTH = 2'h3;
endpackage

// >>> hw/tmr16_edge_det.sv
// event input sampler with two-sample glitch filter and edge select
`timescale 1ns/100ps
module tmr16_edge_det
    import tmr16_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin and selection
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    // detected valid edge
    output logic valid_edge
);
    logic smp_ff;
    logic lvl_ff;
    logic valid_ff;
    logic settled;
    logic rise;
    logic fall;
    logic hit;

    // [RULE14] two equal samples
    assign settled = (pin == smp_ff) && (pin != lvl_ff);
    assign rise = settled && pin;
    assign fall = settled && !pin;
    // [RULE18] edge select decode; code 10 detects nothing
    assign hit = (edge_sel == TMR16_EDGE_RISE && rise) ||
                 (edge_sel == TMR16_EDGE_FALL && fall) ||
                 (edge_sel == TMR16_EDGE_BOTH && settled);
    assign valid_edge = valid_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            smp_ff <= 1'b0;
            lvl_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            smp_ff <= pin;
            if (settled) begin
                lvl_ff <= pin;
            end
            valid_ff <= hit;
        end
    end
endmodule

// >>> hw/tmr16_top.sv
// 16-bit timer/event counter with wishbone register access
// Notes on behaviour
// [RULE1] mode bits 11 start counting on the next count clock tick
// [RULE2] counter equal to primary compare clears it and raises primary irq
// [RULE3] primary compare value M gives one primary irq every M+1 ticks
// [RULE4] software never loads zero into the primary compare register
// [RULE5] secondary irq is raised on every secondary compare match
// [RULE6] software masks secondary irq outside when it does not use it
// [RULE7] output control value 03h gives a square wave in interval mode
// [RULE8] square wave: match clears counter, raises irq, inverts output
// [RULE9] square wave period is two times M+1 count clock periods
// [RULE10] clock select 11 with mode 11 counts valid event pin edges
// [RULE11] software avoids event counting while mode bits are 10
// [RULE12] event mode repeats primary irq every M+1 valid edges
// [RULE13] event mode first primary irq needs M+2 valid edges
// [RULE14] event pin sampled each clock, edge needs two equal samples
// [RULE15] counter register read returns the live count at any time
// [RULE16] capture/compare control all zero keeps primary as a compare
// [RULE17] output enable 0 holds the pin low, 1 drives it from the toggle
// [RULE18] edge select 00 falling, 01 rising, 11 both, 10 prohibited
// [RULE19] software leaves the prescaler register alone while running
// [RULE20] mode bits back to 00 stop the counter and clear it to zero
// [RULE21] primary irq is a one-cycle pulse in the clearing tick
`timescale 1ns/100ps
module tmr16_top
    import tmr16_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // timer pins
    input wire logic event_in_pin,
    output logic timer_out_pin,
    // match requests
    output logic primary_match_irq,
    output logic secondary_match_irq
);
    // the compare registers live in the low half of the data bus
    if (CNT_W < 8 || CNT_W > 16) begin : g_chk
        $error("tmr16_top: CNT_W must lie between 8 and 16");
    end

    // register state
    logic [7:0] mode_control_reg_ff;
    logic [7:0] capcomp_control_reg_ff;
    logic [7:0] output_control_reg_ff;
    logic [7:0] prescaler_mode_reg_ff;
    logic [CNT_W-1:0] primary_compare_ff;
    logic [CNT_W-1:0] secondary_compare_ff;
    // counting state
    logic [CNT_W-1:0] up_counter_ff;
    logic [CNT_W-1:0] nxt_up_counter;
    logic [7:0] div_ff;
    logic [7:0] nxt_div;
    logic started_ff;
    logic out_lvl_ff;
    logic nxt_out_lvl;
    logic pri_irq_ff;
    logic sec_irq_ff;
    // bus state
    logic ack_ff;
    logic [31:0] rdata_ff;

    // bus decode
    logic acc;
    logic wr_now;
    logic [31:0] rd_mux;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic wr_mode;
    logic wr_ccc;
    logic wr_outc;
    logic wr_pre;
    logic wr_pri;
    logic wr_sec;

    // timer decode
    tmr16_mode_t mode;
    logic running;
    logic [1:0] clk_sel;
    logic [1:0] ev_sel;
    logic ev_edge;
    logic tick;
    logic div_end;
    logic count_tick;
    logic pri_hit;
    logic sec_hit;
    logic clr_on_match;
    logic toggle;
    logic set_hi;
    logic set_lo;
    logic inv_pri;
    logic inv_sec;
    logic out_en;

    // register select, shared by every write strobe
    function automatic logic adr_is(input logic [4:0] a, input logic [4:0] reg_adr);
        return a == reg_adr;
    endfunction

    assign acc = wb_cyc_i && wb_stb_i;
    // write lands on the edge at which the master sees ack
    assign wr_now = acc && wb_we_i && ack_ff;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdata = wb_dat_i[15:0];
    assign wr_mode = wr_now && wb_sel_i[0] && adr_is(wb_adr_i, TMR16_ADR_MODE);
    assign wr_ccc = wr_now && wb_sel_i[0] && adr_is(wb_adr_i, TMR16_ADR_CCC);
    assign wr_outc = wr_now && wb_sel_i[0] && adr_is(wb_adr_i, TMR16_ADR_OUTC);
    assign wr_pre = wr_now && wb_sel_i[0] && adr_is(wb_adr_i, TMR16_ADR_PRE);
    // 16-bit registers take each byte lane on its own
    assign wr_pri = wr_now && adr_is(wb_adr_i, TMR16_ADR_PRI);
    assign wr_sec = wr_now && adr_is(wb_adr_i, TMR16_ADR_SEC);

    // [RULE15] live counter on the read path
    always_comb begin
        case (wb_adr_i)
            TMR16_ADR_MODE: rd_mux = {24'h000000, mode_control_reg_ff};
            TMR16_ADR_CCC: rd_mux = {24'h000000, capcomp_control_reg_ff};
            TMR16_ADR_OUTC:
                rd_mux = {24'h000000, output_control_reg_ff & TMR16_OC_RD_MASK};
            TMR16_ADR_PRE: rd_mux = {24'h000000, prescaler_mode_reg_ff};
            TMR16_ADR_CNT: rd_mux = {16'h0000, 16'(up_counter_ff)};
            TMR16_ADR_PRI: rd_mux = {16'h0000, 16'(primary_compare_ff)};
            TMR16_ADR_SEC: rd_mux = {16'h0000, 16'(secondary_compare_ff)};
            TMR16_ADR_STAT: rd_mux = {30'h0, started_ff, out_lvl_ff};
            default: rd_mux = 32'h00000000;
        endcase
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            // ack drops after one cycle so a held request is not answered twice
            ack_ff <= acc && !ack_ff;
            // value at the request edge stands together with ack
            rdata_ff <= rd_mux;
        end
    end

    // control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_control_reg_ff <= TMR16_RST_8;
            capcomp_control_reg_ff <= TMR16_RST_8;
            prescaler_mode_reg_ff <= TMR16_RST_8;
            output_control_reg_ff <= TMR16_RST_8;
        end else begin
            if (wr_mode) begin
                mode_control_reg_ff <= wdata[7:0] & TMR16_MODE_MASK;
            end
            if (wr_ccc) begin
                capcomp_control_reg_ff <= wdata[7:0] & TMR16_CCC_MASK;
            end
            if (wr_pre) begin
                prescaler_mode_reg_ff <= wdata[7:0] & TMR16_PRE_MASK;
            end
            if (wr_outc) begin
                output_control_reg_ff <= wdata[7:0];
            end
        end
    end

    // compare registers honour byte lanes
    always_ff @(posedge clk) begin
        if (rst) begin
            primary_compare_ff <= CNT_W'(TMR16_RST_16);
            secondary_compare_ff <= CNT_W'(TMR16_RST_16);
        end else begin
            if (wr_pri) begin
                primary_compare_ff <= CNT_W'((16'(primary_compare_ff) & ~wmask) |
                                             (wdata & wmask));
            end
            if (wr_sec) begin
                secondary_compare_ff <= CNT_W'((16'(secondary_compare_ff) & ~wmask) |
                                               (wdata & wmask));
            end
        end
    end

    // event pin edge detection
    assign ev_sel = prescaler_mode_reg_ff[TMR16_PRE_EV_LO +: 2];

    // filter tracks the pin while stopped, so a restart sees no stale edge
    tmr16_edge_det u_edge (
        .clk(clk),
        .rst(rst),
        .pin(event_in_pin),
        .edge_sel(ev_sel),
        .valid_edge(ev_edge)
    );

    assign mode = tmr16_mode_t'(mode_control_reg_ff[TMR16_MODE_HI:TMR16_MODE_LO]);
    assign running = mode != TMR16_MODE_STOP;
    assign clk_sel = prescaler_mode_reg_ff[TMR16_PRE_CLK_LO +: 2];

    // count clock selection
    always_comb begin
        case (clk_sel)
            TMR16_CLK_DIV1: div_end = 1'b1;
            TMR16_CLK_DIV4: div_end = div_ff == TMR16_DIV4_END;
            TMR16_CLK_DIV256: div_end = div_ff == TMR16_DIV256_END;
            default: div_end = 1'b0;
        endcase
    end

    // [RULE10] event edges become the count clock
    assign tick = running && (clk_sel == TMR16_CLK_EVENT ? ev_edge : div_end);
    // divider restarts whenever the timer stops so the first period is whole
    assign nxt_div = (!running || div_end) ? 8'h00 : div_ff + 8'h01;

    // [RULE1] first tick after start only synchronises
    // [RULE13] so the first match in event mode takes M+2 edges
    assign count_tick = tick && started_ff;

    // [RULE16] primary always acts as a compare register
    assign pri_hit = count_tick && up_counter_ff == primary_compare_ff;
    // [RULE5] secondary match raised regardless of use
    assign sec_hit = count_tick && up_counter_ff == secondary_compare_ff;
    assign clr_on_match = pri_hit && mode == TMR16_MODE_MATCH_CLR;

    // [RULE2] clear on primary match
    // [RULE3] one match every M+1 count ticks
    // [RULE12] repeat every M+1 edges in event mode
    // [RULE20] stopped counter held at zero
    always_comb begin
        if (!running || clr_on_match) begin
            nxt_up_counter = '0;
        end else if (count_tick) begin
            nxt_up_counter = up_counter_ff + CNT_W'(1);
        end else begin
            nxt_up_counter = up_counter_ff;
        end
    end

    // [RULE8] output inverts on compare match when enabled
    assign inv_pri = output_control_reg_ff[TMR16_OC_INV_PRI];
    assign inv_sec = output_control_reg_ff[TMR16_OC_INV_SEC];
    assign toggle = (pri_hit && inv_pri) || (sec_hit && inv_sec);
    // both triggers at once leave the level unchanged
    assign set_hi = wr_outc && wdata[TMR16_OC_SET_HI] && !wdata[TMR16_OC_SET_LO];
    assign set_lo = wr_outc && wdata[TMR16_OC_SET_LO] && !wdata[TMR16_OC_SET_HI];

    // [RULE9] toggling every M+1 ticks gives a 2(M+1) period
    always_comb begin
        if (set_hi) begin
            nxt_out_lvl = 1'b1;
        end else if (set_lo) begin
            nxt_out_lvl = 1'b0;
        end else if (toggle && running) begin
            nxt_out_lvl = !out_lvl_ff;
        end else begin
            nxt_out_lvl = out_lvl_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            up_counter_ff <= '0;
            div_ff <= 8'h00;
            started_ff <= 1'b0;
            out_lvl_ff <= 1'b0;
            pri_irq_ff <= 1'b0;
            sec_irq_ff <= 1'b0;
        end else begin
            up_counter_ff <= nxt_up_counter;
            div_ff <= nxt_div;
            started_ff <= running && (started_ff || tick);
            out_lvl_ff <= nxt_out_lvl;
            // [RULE21] one-cycle match pulses
            pri_irq_ff <= pri_hit;
            sec_irq_ff <= sec_hit;
        end
    end

    assign primary_match_irq = pri_irq_ff;
    assign secondary_match_irq = sec_irq_ff;
    assign out_en = output_control_reg_ff[TMR16_OC_OE];
    // [RULE17] pin low unless output enabled
    // toggle level keeps running while disabled, so enabling shows its phase
    assign timer_out_pin = out_en && out_lvl_ff;
endmodule

// >>> sim/tmr16_checker.sv
// concurrent checks on the timer's bus, output pin and match requests
`timescale 1ns/100ps
module tmr16_checker
    import tmr16_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and requests
    input wire logic event_in_pin,
    input wire logic timer_out_pin,
    input wire logic primary_match_irq,
    input wire logic secondary_match_irq
);
    logic [1:0] mode_ff, clk_ff;
    logic oe_ff, ok_ff;
    logic [CNT_W-1:0] pri_ff;
    logic [CNT_W:0] gap_ff;
    // shadow of the fields the checks depend on, taken at the write edge
    wire logic wr_hit = wb_ack_o && wb_we_i && wb_cyc_i && wb_stb_i;
    wire logic wr_mode = wr_hit && wb_sel_i[0] && wb_adr_i == TMR16_ADR_MODE;
    wire logic wr_pre = wr_hit && wb_sel_i[0] && wb_adr_i == TMR16_ADR_PRE;
    wire logic wr_outc = wr_hit && wb_sel_i[0] && wb_adr_i == TMR16_ADR_OUTC;
    wire logic wr_pri = wr_hit && (&wb_sel_i[1:0]) && wb_adr_i == TMR16_ADR_PRI;
    wire logic run_div1 = mode_ff == 2'h3 && clk_ff == TMR16_CLK_DIV1;
    wire logic stopped = mode_ff == 2'h0;
    always_ff @(posedge clk) mode_ff <= rst ? 2'h0 : wr_mode ? wb_dat_i[3:2] : mode_ff;
    always_ff @(posedge clk) clk_ff <= rst ? 2'h0 : wr_pre ? wb_dat_i[1:0] : clk_ff;
    always_ff @(posedge clk) oe_ff <= rst ? 1'b0 : wr_outc ? wb_dat_i[0] : oe_ff;
    always_ff @(posedge clk) pri_ff <= rst ? '0 : wr_pri ? wb_dat_i[CNT_W-1:0] : pri_ff;
    // cycles since the last primary request; a write spoils the measured period
    always_ff @(posedge clk) gap_ff <= primary_match_irq ? {{CNT_W{1'b0}}, 1'b1} : gap_ff + 1'b1;
    always_ff @(posedge clk) ok_ff <= (rst || wr_hit) ? 1'b0 : primary_match_irq ? 1'b1 : ok_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_irq_pulse: assert property (primary_match_irq |=> !primary_match_irq)
        else $error("primary request longer than one cycle");
    chk_sec_pulse: assert property (secondary_match_irq |=> !secondary_match_irq)
        else $error("secondary request longer than one cycle");
    chk_pri_period: assert property (primary_match_irq && ok_ff && run_div1 |->
        gap_ff == {1'b0, pri_ff} + 1'b1)
        else $error("primary request period differs from compare plus one");
    chk_oe_low: assert property (!oe_ff |-> !timer_out_pin)
        else $error("output pin high while output disabled");
    chk_pin_cause: assert property ($changed(timer_out_pin) && !$past(wb_ack_o) |->
        ((primary_match_irq || $past(primary_match_irq)) or (##1 primary_match_irq)))
        else $error("output pin changed without a primary match");
    chk_stop_quiet: assert property (stopped && $past(mode_ff) == 2'h0 &&
        $past(mode_ff, 2) == 2'h0 |-> !primary_match_irq && !secondary_match_irq)
        else $error("match request while stopped");
    chk_stop_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == TMR16_ADR_CNT &&
        stopped && $past(mode_ff) == 2'h0 |-> wb_dat_o == 32'h0)
        else $error("counter not zero while stopped");
endmodule

// >>> sim/test_tmr16_top.sv
// self-checking testbench for the 16-bit timer with wishbone access
`timescale 1ns/100ps
module test_tmr16_top import tmr16_pkg::*; ;
    localparam int CNT_W = 16;
    localparam int LIMIT = 20000;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ev_pin = 0;
    logic [4:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0, dat_o, rd_val, seed = 32'h1a83;
    logic ack, pin_o, pri_irq, sec_irq;
    logic [32:0] rq[$];
    logic [4:0] ra[4] = '{TMR16_ADR_MODE, TMR16_ADR_CCC, TMR16_ADR_OUTC, TMR16_ADR_PRE};
    logic [7:0] rv[4] = '{8'hf2, 8'hff, 8'hff, 8'hff};
    logic [7:0] rm[4] = '{TMR16_MODE_MASK, TMR16_CCC_MASK, TMR16_OC_RD_MASK, TMR16_PRE_MASK};
    logic [1:0] es[3] = '{TMR16_EDGE_FALL, TMR16_EDGE_RISE, TMR16_EDGE_BOTH};
    int err_total = 0, checks_done = 0, cycles = 0, pri_cnt = 0, sec_cnt = 0;
    int m, n, ed, s0;

    tmr16_top #(.CNT_W(CNT_W)) dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .event_in_pin(ev_pin), .timer_out_pin(pin_o),
        .primary_match_irq(pri_irq), .secondary_match_irq(sec_irq));

    initial begin
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one classic cycle, held until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic c);
        rq.push_back({c, e});
        bus(1'b0, a, 32'h0);
    endtask

    // cycles between two consecutive primary requests (w=0) or pin changes (w=1)
    task automatic gap(input logic w, output int cnt);
        logic p;
        repeat (2) begin
            cnt = 0;
            p = pin_o;
            do begin
                @(posedge clk);
                #1;
                cnt++;
            end while (!(w ? pin_o !== p : pri_irq === 1'b1) && cnt < 2000);
        end
    endtask

    // one-cycle glitch toward the new level, then a settled level change
    task automatic step(input logic [1:0] e, inout int cnt);
        ev_pin <= ~ev_pin;
        @(posedge clk);
        ev_pin <= ~ev_pin;
        repeat (2) @(posedge clk);
        ev_pin <= ~ev_pin;
        repeat (8) @(posedge clk);
        if (e == TMR16_EDGE_BOTH || e[0] == ev_pin) cnt++;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (pri_irq === 1'b1) pri_cnt++;
        if (sec_irq === 1'b1) sec_cnt++;
        if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) begin
            rd_val = dat_o;
            if (rq[0][32]) check(dat_o, rq[0][31:0]);
            void'(rq.pop_front());
        end
        if (cycles >= LIMIT) begin
            err_total++;
            test_done;
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0, 1'b1);
        rd(5'h02, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(ra[i], {24'hffffff, rv[i]});
            rd(ra[i], {24'h0, rv[i] & rm[i]}, 1'b1);
            wr(ra[i], 32'h0);
        end
        wr(TMR16_ADR_CNT, 32'hffff);
        rd(TMR16_ADR_CNT, 32'h0, 1'b1);
        seed = xs(seed);
        wr(TMR16_ADR_PRI, seed);
        rd(TMR16_ADR_PRI, {16'h0, seed[15:0]}, 1'b1);
        wr(TMR16_ADR_SEC, ~seed);
        rd(TMR16_ADR_SEC, {16'h0, ~seed[15:0]}, 1'b1);
        $display("test registers done");
        seed = xs(seed);
        m = 3 + seed[2:0];
        // secondary is used here, so its request stays unmasked
        wr(TMR16_ADR_PRI, m);
        wr(TMR16_ADR_SEC, m - 1);
        wr(TMR16_ADR_OUTC, 32'h03);
        wr(TMR16_ADR_MODE, 32'h0c);
        gap(1'b0, n);
        s0 = sec_cnt;
        gap(1'b0, n);
        check(n, m + 1);
        check(sec_cnt - s0, 2);
        gap(1'b1, n);
        check(n, m + 1);
        rd(TMR16_ADR_CNT, 32'h0, 1'b0);
        check(rd_val <= m, 1);
        wr(TMR16_ADR_OUTC, 32'h09);
        check(pin_o, 1);
        wr(TMR16_ADR_OUTC, 32'h05);
        check(pin_o, 0);
        wr(TMR16_ADR_MODE, 32'h0);
        rd(TMR16_ADR_CNT, 32'h0, 1'b1);
        $display("test interval and square wave done");
        // event counting only with mode 11
        for (int i = 0; i < 3; i++) begin
            wr(TMR16_ADR_PRE, {2'h0, es[i], 2'h0, TMR16_CLK_EVENT});
            wr(TMR16_ADR_PRI, 32'h4);
            wr(TMR16_ADR_MODE, 32'h0c);
            for (int r = 0; r < 2; r++) begin
                ed = 0;
                s0 = pri_cnt;
                while (pri_cnt == s0 && ed < 20) step(es[i], ed);
                check(ed, r ? 5 : 6);
            end
            wr(TMR16_ADR_MODE, 32'h0);
            ev_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        $display("test event counting done");
        test_done;
    end
endmodule

bind tmr16_top tmr16_checker #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_in_pin(event_in_pin), .timer_out_pin(timer_out_pin),
    .primary_match_irq(primary_match_irq), .secondary_match_irq(secondary_match_irq));
